// ---- logic/hub_reset_config_sequencer.sv ----
// The address map and the APB interface to the registers are this design's own decisions.
module hub_reset_config_sequencer #(
	parameter logic [21:0] RECOVER_CYC = 22'(hub_seq_pkg::RECOVER_CYC),
	parameter logic [21:0] EE_TMO_CYC = 22'(hub_seq_pkg::EE_READ_CYC),
	parameter logic [17:0] REQ_TMO_CYC = 18'(hub_seq_pkg::REQ_CYC)
) (
	// Clock and hardware reset
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	// Straps
	input wire logic [1:0] CFG_SEL_I,
	input wire logic [hub_seq_pkg::NUM_PORTS-1:0] CHARGE_PORT_EN_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [hub_seq_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// EEPROM reader engine
	output logic EE_START_O,
	input wire logic EE_DONE_I,
	input wire logic EE_PRESENT_I,
	input wire logic [7:0] EE_DATA_I,
	// SMBus load engine
	input wire logic SMB_LOAD_DONE_I,
	// Upstream link events
	input wire logic USB_BUS_RESET_I,
	input wire logic SUSPEND_I,
	input wire logic REQ_START_I,
	input wire logic REQ_DONE_I,
	// Controls to the hub
	output logic OSC_ENABLE_O,
	output logic PLL_ENABLE_O,
	output logic PHY_ENABLE_O,
	output logic OUTPUT_DRIVE_O,
	output logic STRAP_OVERRIDE_O,
	output logic ATTACH_O,
	output logic [hub_seq_pkg::NUM_PORTS-1:0] PORT_ENABLE_O,
	output logic [hub_seq_pkg::NUM_PORTS-1:0] PORT_POWER_O,
	output logic [hub_seq_pkg::USB_ADDR_W-1:0] USB_ADDR_O,
	output logic CONFIGURED_O,
	output logic SUSPENDED_O,
	output logic TT_FLUSH_O,
	output logic REQ_ABORT_O,
	output logic [7:0] CONFIG_O
);
	localparam int DRV_LIM = hub_seq_pkg::OUT_DRV_CYC;

	hub_seq_pkg::seq_state_e state_r, state_nxt;
	hub_seq_pkg::cfg_mode_e mode_r, mode_nxt;
	logic [21:0] cnt_r, cnt_nxt;
	logic [7:0] config_r, config_nxt;
	logic ovr_r, ovr_nxt;
	logic drive_r, drive_nxt;
	logic attach_r, attach_nxt;
	logic ee_start_r, ee_start_nxt;
	logic phy_r, phy_nxt;
	logic clk_en_r, clk_en_nxt;
	logic [6:0] addr_r, addr_nxt;
	logic conf_r, conf_nxt;
	logic susp_r, susp_nxt;
	logic flush_r, flush_nxt;
	logic req_busy_r, req_busy_nxt;
	logic [17:0] req_cnt_r, req_cnt_nxt;
	logic abort_r, abort_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic slverr_r, slverr_nxt;
	logic wr_en;
	logic attach_wr;
	logic cfg_wr;
	logic dev_wr;

	function automatic hub_seq_pkg::cfg_mode_e decode_mode(input logic [1:0] sel);
		case (sel)
			hub_seq_pkg::STRAP_DEFAULT: decode_mode = hub_seq_pkg::MODE_STRAP;
			hub_seq_pkg::STRAP_SMBUS: decode_mode = hub_seq_pkg::MODE_SMBUS;
			default: decode_mode = hub_seq_pkg::MODE_EEPROM;
		endcase
	endfunction

	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a == hub_seq_pkg::CTRL_OFS) || (a == hub_seq_pkg::CONFIG_OFS) ||
			(a == hub_seq_pkg::DEV_OFS) || (a == hub_seq_pkg::STATUS_OFS);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// APB decode
	assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
	assign attach_wr = wr_en && (PADDR_I == hub_seq_pkg::CTRL_OFS) && PWDATA_I[hub_seq_pkg::CTRL_ATTACH_BIT];
	assign cfg_wr = wr_en && (PADDR_I == hub_seq_pkg::CONFIG_OFS);
	assign dev_wr = wr_en && (PADDR_I == hub_seq_pkg::DEV_OFS);
	// Zero wait state: read data is captured in the setup cycle
	assign PREADY_O = 1'b1;
	assign PRDATA_O = prdata_r;
	assign PSLVERR_O = slverr_r;

	always_comb begin
		prdata_nxt = prdata_r;
		slverr_nxt = slverr_r;
		if (PSEL_I && !PENABLE_I) begin
			slverr_nxt = !reg_hit(PADDR_I);
			prdata_nxt = 32'h0;
			case (PADDR_I)
				hub_seq_pkg::CTRL_OFS: prdata_nxt[hub_seq_pkg::CTRL_ATTACH_BIT] = attach_r;
				hub_seq_pkg::CONFIG_OFS: prdata_nxt[7:0] = config_r;
				hub_seq_pkg::DEV_OFS: begin
					prdata_nxt[6:0] = addr_r;
					prdata_nxt[hub_seq_pkg::DEV_CONF_BIT] = conf_r;
				end
				hub_seq_pkg::STATUS_OFS: begin
					prdata_nxt[hub_seq_pkg::ST_STATE_LSB +: 3] = state_r;
					prdata_nxt[hub_seq_pkg::ST_MODE_LSB +: 2] = mode_r;
					prdata_nxt[hub_seq_pkg::ST_ATTACH_BIT] = attach_r;
					prdata_nxt[hub_seq_pkg::ST_SUSP_BIT] = susp_r;
					prdata_nxt[hub_seq_pkg::ST_REQ_BIT] = req_busy_r;
					prdata_nxt[hub_seq_pkg::ST_OVR_BIT] = ovr_r;
				end
				default: prdata_nxt = 32'h0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			prdata_r <= 32'h0;
			slverr_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Start-up sequencer
	always_comb begin
		state_nxt = state_r;
		mode_nxt = mode_r;
		cnt_nxt = cnt_r;
		config_nxt = config_r;
		ovr_nxt = ovr_r;
		drive_nxt = drive_r;
		attach_nxt = attach_r;
		phy_nxt = phy_r;
		ee_start_nxt = 1'b0;
		clk_en_nxt = 1'b1; // RL8
		case (state_r)
			hub_seq_pkg::ST_LATCH: begin
				// First edge after release; CFG_SEL_I never sampled again
				mode_nxt = decode_mode(CFG_SEL_I); // RL26
				cnt_nxt = 22'h0;
				state_nxt = hub_seq_pkg::ST_RECOVER;
			end
			hub_seq_pkg::ST_RECOVER: begin
				if (cnt_r == RECOVER_CYC - 22'h1) begin // RL25 RL9
					cnt_nxt = 22'h0;
					phy_nxt = 1'b1;
					case (mode_r) // RL10
						hub_seq_pkg::MODE_STRAP: state_nxt = hub_seq_pkg::ST_STRAP;
						hub_seq_pkg::MODE_EEPROM: begin
							state_nxt = hub_seq_pkg::ST_EEPROM;
							ee_start_nxt = 1'b1;
						end
						default: state_nxt = hub_seq_pkg::ST_SMBUS;
					endcase
				end else begin
					cnt_nxt = cnt_r + 22'h1;
				end
			end
			hub_seq_pkg::ST_STRAP: begin
				config_nxt = hub_seq_pkg::CONFIG_DEFAULT; // RL1 RL2
				ovr_nxt = 1'b1; // RL1
				drive_nxt = 1'b1; // RL11
				state_nxt = hub_seq_pkg::ST_ATTACH;
			end
			hub_seq_pkg::ST_EEPROM: begin
				if (EE_DONE_I) begin
					config_nxt = EE_PRESENT_I ? EE_DATA_I : hub_seq_pkg::CONFIG_RESET; // RL24
					state_nxt = hub_seq_pkg::ST_ATTACH;
				end else if (cnt_r == EE_TMO_CYC - 22'h1) begin // RL12
					// A hung reader is treated as an absent part
					config_nxt = hub_seq_pkg::CONFIG_RESET;
					state_nxt = hub_seq_pkg::ST_ATTACH;
				end else begin
					cnt_nxt = cnt_r + 22'h1;
				end
			end
			hub_seq_pkg::ST_SMBUS: begin
				// No timeout here: the loader, or an attach write, decides how long it takes
				if (SMB_LOAD_DONE_I || attach_wr) begin // RL22 RL23
					state_nxt = hub_seq_pkg::ST_ATTACH;
				end
			end
			hub_seq_pkg::ST_ATTACH: begin
				attach_nxt = 1'b1; // RL13
				drive_nxt = 1'b1;
				state_nxt = hub_seq_pkg::ST_RUN;
			end
			hub_seq_pkg::ST_RUN: state_nxt = hub_seq_pkg::ST_RUN;
			default: state_nxt = hub_seq_pkg::ST_LATCH;
		endcase
		if (cfg_wr && !attach_r && state_r != hub_seq_pkg::ST_EEPROM) begin
			config_nxt = PWDATA_I[7:0]; // RL23
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin // RL6 RL7
			state_r <= hub_seq_pkg::ST_LATCH;
			mode_r <= hub_seq_pkg::MODE_STRAP;
			cnt_r <= 22'h0;
			config_r <= hub_seq_pkg::CONFIG_RESET;
			ovr_r <= 1'b0;
			drive_r <= 1'b0;
			attach_r <= 1'b0;
			phy_r <= 1'b0; // RL5
			ee_start_r <= 1'b0;
			clk_en_r <= 1'b0; // RL8
		end else begin
			state_r <= state_nxt;
			mode_r <= mode_nxt;
			cnt_r <= cnt_nxt;
			config_r <= config_nxt;
			ovr_r <= ovr_nxt;
			drive_r <= drive_nxt;
			attach_r <= attach_nxt;
			phy_r <= phy_nxt;
			ee_start_r <= ee_start_nxt;
			clk_en_r <= clk_en_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Upstream device state
	always_comb begin
		addr_nxt = addr_r;
		conf_nxt = conf_r;
		susp_nxt = susp_r;
		flush_nxt = 1'b0;
		abort_nxt = 1'b0;
		req_busy_nxt = req_busy_r;
		req_cnt_nxt = req_cnt_r;
		if (dev_wr && attach_r) begin
			addr_nxt = PWDATA_I[6:0];
			conf_nxt = PWDATA_I[hub_seq_pkg::DEV_CONF_BIT];
		end
		if (SUSPEND_I) begin
			susp_nxt = 1'b1;
		end
		if (req_busy_r) begin
			if (REQ_DONE_I) begin
				req_busy_nxt = 1'b0;
			end else if (req_cnt_r == REQ_TMO_CYC - 18'h1) begin // RL16
				abort_nxt = 1'b1;
				req_busy_nxt = 1'b0;
			end else begin
				req_cnt_nxt = req_cnt_r + 18'h1;
			end
		end else if (REQ_START_I && attach_r) begin
			req_busy_nxt = 1'b1;
			req_cnt_nxt = 18'h0;
		end
		// Local only: nothing here reaches a downstream port reset
		if (USB_BUS_RESET_I) begin // RL21
			addr_nxt = 7'h0; // RL17
			conf_nxt = 1'b0; // RL17 RL18
			susp_nxt = 1'b0; // RL20
			flush_nxt = 1'b1; // RL19
			req_busy_nxt = 1'b0;
			req_cnt_nxt = 18'h0;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin // RL6
			addr_r <= 7'h0;
			conf_r <= 1'b0;
			susp_r <= 1'b0;
			flush_r <= 1'b0;
			abort_r <= 1'b0;
			req_busy_r <= 1'b0;
			req_cnt_r <= 18'h0;
		end else begin
			addr_r <= addr_nxt;
			conf_r <= conf_nxt;
			susp_r <= susp_nxt;
			flush_r <= flush_nxt;
			abort_r <= abort_nxt;
			req_busy_r <= req_busy_nxt;
			req_cnt_r <= req_cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign OSC_ENABLE_O = clk_en_r;
	assign PLL_ENABLE_O = clk_en_r;
	assign PHY_ENABLE_O = phy_r;
	assign OUTPUT_DRIVE_O = drive_r;
	assign STRAP_OVERRIDE_O = ovr_r;
	assign ATTACH_O = attach_r;
	assign EE_START_O = ee_start_r;
	assign PORT_ENABLE_O = {hub_seq_pkg::NUM_PORTS{conf_r}}; // RL4
	// Charging ports keep power through both resets
	assign PORT_POWER_O = {hub_seq_pkg::NUM_PORTS{conf_r}} | CHARGE_PORT_EN_I; // RL4 RL18
	assign USB_ADDR_O = addr_r;
	assign CONFIGURED_O = conf_r;
	assign SUSPENDED_O = susp_r;
	assign TT_FLUSH_O = flush_r;
	assign REQ_ABORT_O = abort_r;
	assign CONFIG_O = config_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	strap_default_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL1
		state_r == hub_seq_pkg::ST_STRAP |=> config_r == hub_seq_pkg::CONFIG_DEFAULT && ovr_r ##1 ATTACH_O)
		else $error("strap path did not load defaults");
	reset_quiet_a: assert property (@(posedge SYS_CLK_I) // RL4
		!RESETN_I |=> PORT_ENABLE_O == 4'h0 && !PHY_ENABLE_O && !OSC_ENABLE_O && !PLL_ENABLE_O)
		else $error("hub not quiet after reset");
	recover_time_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL9
		$fell(state_r == hub_seq_pkg::ST_RECOVER) |-> $past(cnt_r) == RECOVER_CYC - 22'h1 && phy_r)
		else $error("recovery interval wrong");
	straps_held_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL26
		state_r != hub_seq_pkg::ST_LATCH |=> $stable(mode_r))
		else $error("strap mode changed after latch");
	strap_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL11
		$rose(state_r == hub_seq_pkg::ST_STRAP) |-> ##[1:DRV_LIM] OUTPUT_DRIVE_O)
		else $error("outputs not driven in time");
	ee_timeout_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL12
		state_r == hub_seq_pkg::ST_EEPROM && !EE_DONE_I && cnt_r == EE_TMO_CYC - 22'h1
		|=> state_r == hub_seq_pkg::ST_ATTACH && config_r == hub_seq_pkg::CONFIG_RESET)
		else $error("eeprom timeout not taken");
	no_eeprom_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL24
		state_r == hub_seq_pkg::ST_EEPROM && EE_DONE_I && !EE_PRESENT_I |=> config_r == 8'h00)
		else $error("absent eeprom left config set");
	attach_time_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL13
		state_r == hub_seq_pkg::ST_ATTACH |=> ATTACH_O && state_r == hub_seq_pkg::ST_RUN)
		else $error("attach not signalled");
	smbus_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL22
		state_r == hub_seq_pkg::ST_SMBUS && !SMB_LOAD_DONE_I && !attach_wr
		|=> state_r == hub_seq_pkg::ST_SMBUS && !ATTACH_O)
		else $error("attached before smbus load");
	write_protect_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL23
		attach_r && cfg_wr |=> $stable(config_r))
		else $error("config written after attach");
	bus_reset_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL17
		USB_BUS_RESET_I |=> addr_r == 7'h0 && !conf_r && !susp_r && TT_FLUSH_O && PORT_ENABLE_O == 4'h0)
		else $error("bus reset effects missing");
	req_abort_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL16
		req_busy_r && !REQ_DONE_I && !USB_BUS_RESET_I && req_cnt_r == REQ_TMO_CYC - 18'h1
		|=> REQ_ABORT_O && !req_busy_r)
		else $error("request watchdog missed");
	clocks_run_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL8
		$past(RESETN_I) |-> OSC_ENABLE_O && PLL_ENABLE_O)
		else $error("clocks not running after release");
	ee_start_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL10
		$rose(state_r == hub_seq_pkg::ST_EEPROM) |-> EE_START_O)
		else $error("eeprom reader not started");
	suspend_set_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I) // RL20
		SUSPEND_I && !USB_BUS_RESET_I |=> SUSPENDED_O)
		else $error("suspend not recorded");

	strap_path_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		state_r == hub_seq_pkg::ST_STRAP ##2 ATTACH_O);
	eeprom_path_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		state_r == hub_seq_pkg::ST_EEPROM && EE_DONE_I && EE_PRESENT_I);
	smbus_attach_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		state_r == hub_seq_pkg::ST_SMBUS && attach_wr);
	bus_reset_c: cover property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		susp_r && USB_BUS_RESET_I);
endmodule // hub_reset_config_sequencer

// ---- include/hub_seq_pkg.sv ----
// Overview of operation
// RL1 - Straps 00b load defaults, enable overrides
// RL2 - Unstrapped registers take built-in defaults
// RL3 - Host holds reset low at least 1 us
// RL4 - Reset disables ports, power only charge ports
// RL5 - Reset disables PHYs, pairs high impedance
// RL6 - Reset aborts all transactions, keeps nothing
// RL7 - Reset returns registers to defaults
// RL8 - Reset stops oscillator and PLL
// RL9 - Operational within 500 us of release
// RL10 - Run exactly one configuration path
// RL11 - Strap mode drives outputs inactive within 2 us
// RL12 - EEPROM read bounded by 99.5 ms
// RL13 - Attach within 100 ms of configuration
// RL14 - SMBus host loads within 99.5 ms bus-powered
// RL15 - Host waits 100 ms before bus reset
// RL16 - Control requests complete within 5 ms
// RL17 - Bus reset clears address, unconfigures
// RL18 - Bus reset removes port power except charging
// RL19 - Bus reset flushes TT buffers
// RL20 - Bus reset wakes from suspend
// RL21 - Bus reset never passed downstream
// RL22 - SMBus mode waits unbounded, then attaches
// RL23 - Attach bit attaches and write-protects configuration
// RL24 - Absent EEPROM zeroes configuration
// RL25 - Recovery counted, logic held meanwhile
// RL26 - Straps latched once at reset release; CHARGE_PORT_EN_I is not latched but drives PORT_POWER_O live
package hub_seq_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
	localparam int unsigned RECOVER_US = 500;
	localparam int unsigned RECOVER_CYC = RECOVER_US * CLK_MHZ;
	localparam int unsigned OUT_DRV_US = 2;
	localparam int unsigned OUT_DRV_CYC = OUT_DRV_US * CLK_MHZ;
	localparam real EE_READ_MAX_MS = 99.5;
	localparam int unsigned EE_READ_CYC = int'(EE_READ_MAX_MS * 1000.0) * CLK_MHZ;
	localparam int unsigned REQ_MAX_MS = 5;
	localparam int unsigned REQ_CYC = REQ_MAX_MS * 1000 * CLK_MHZ;
	localparam int unsigned TMR_W = 22;
	localparam int unsigned REQ_W = 18;
	localparam int unsigned NUM_PORTS = 4;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned USB_ADDR_W = 7;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CONFIG_OFS = 8'h04;
	localparam logic [7:0] DEV_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0c;
	localparam int unsigned CTRL_ATTACH_BIT = 0;
	localparam int unsigned DEV_CONF_BIT = 8;
	localparam int unsigned ST_STATE_LSB = 0;
	localparam int unsigned ST_MODE_LSB = 4;
	localparam int unsigned ST_ATTACH_BIT = 8;
	localparam int unsigned ST_SUSP_BIT = 9;
	localparam int unsigned ST_REQ_BIT = 10;
	localparam int unsigned ST_OVR_BIT = 11;
	// Built-in configuration default, value arbitrary
	localparam logic [7:0] CONFIG_DEFAULT = 8'ha5;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [1:0] STRAP_DEFAULT = 2'h0;
	localparam logic [1:0] STRAP_EEPROM = 2'h1;
	localparam logic [1:0] STRAP_SMBUS = 2'h2;

	typedef enum logic [2:0] {
		ST_LATCH = 3'h0,
		ST_RECOVER = 3'h1,
		ST_STRAP = 3'h2,
		ST_EEPROM = 3'h3,
		ST_SMBUS = 3'h4,
		ST_ATTACH = 3'h5,
		ST_RUN = 3'h6
	} seq_state_e;

	typedef enum logic [1:0] {
		MODE_STRAP = 2'h0,
		MODE_EEPROM = 2'h1,
		MODE_SMBUS = 2'h2
	} cfg_mode_e;
endpackage

// ---- test/hub_far_side_model.sv ----
module hub_far_side_model (
	// Clock
	input wire logic clk_i,
	// Scenario controls
	input wire logic [3:0] ee_lat_i,
	input wire logic ee_hang_i,
	input wire logic ee_fit_i,
	input wire logic [7:0] ee_byte_i,
	input wire logic smb_go_i,
	// To and from the sequencer
	input wire logic ee_start_i,
	output logic ee_done_o,
	output logic ee_present_o,
	output logic [7:0] ee_data_o,
	output logic smb_done_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_r = 4'h0;
	initial begin
		ee_done_o = 1'b0;
		ee_present_o = 1'b0;
		ee_data_o = 8'h5a;
		smb_done_o = 1'b0;
	end
	always @(posedge clk_i) begin
		ee_done_o <= 1'b0;
		ee_present_o <= ee_fit_i;
		// Byte is only valid with done: keep it moving otherwise
		ee_data_o <= ~ee_data_o;
		if (ee_start_i === 1'b1 && !ee_hang_i) begin
			cnt_r <= ee_lat_i;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
			if (cnt_r == 4'h1) begin
				ee_done_o <= 1'b1;
				ee_data_o <= ee_byte_i;
			end
		end
		smb_done_o <= smb_go_i;
	end
endmodule // hub_far_side_model

// ---- test/test_hub_reset_config_sequencer.sv ----
module test_hub_reset_config_sequencer;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [21:0] RCV = 22'h14;
	localparam logic [21:0] EET = 22'h32;
	localparam logic [17:0] RQT = 18'h1e;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic bus_rst = 1'b0, suspend = 1'b0, req_start = 1'b0, req_done = 1'b0;
	logic ee_hang = 1'b0, ee_fit = 1'b0, smb_go = 1'b0, er;
	logic [1:0] cfg_sel = 2'h0;
	logic [3:0] charge_en = 4'h0, ee_lat = 4'h3;
	logic [7:0] paddr = 8'h0, ee_byte = 8'h0, cfg_r;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, ee_start, ee_done, ee_present, smb_done, osc_en, pll_en, phy_en;
	logic out_drv, strap_ovr, attach, configured, suspended, tt_flush, req_abort, seen;
	logic [3:0] port_en, port_pwr;
	logic [6:0] usb_addr, ua;
	logic [7:0] ee_data, config_byte;
	int err_total = 0, checks_done = 0, n;
	always #12.5 clk = ~clk;
	hub_reset_config_sequencer #(.RECOVER_CYC(RCV), .EE_TMO_CYC(EET), .REQ_TMO_CYC(RQT)) u_dut (
		.SYS_CLK_I(clk), .RESETN_I(rst_n), .CFG_SEL_I(cfg_sel), .CHARGE_PORT_EN_I(charge_en),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .EE_START_O(ee_start),
		.EE_DONE_I(ee_done), .EE_PRESENT_I(ee_present), .EE_DATA_I(ee_data), .SMB_LOAD_DONE_I(smb_done),
		.USB_BUS_RESET_I(bus_rst), .SUSPEND_I(suspend), .REQ_START_I(req_start), .REQ_DONE_I(req_done),
		.OSC_ENABLE_O(osc_en), .PLL_ENABLE_O(pll_en), .PHY_ENABLE_O(phy_en), .OUTPUT_DRIVE_O(out_drv),
		.STRAP_OVERRIDE_O(strap_ovr), .ATTACH_O(attach), .PORT_ENABLE_O(port_en), .PORT_POWER_O(port_pwr),
		.USB_ADDR_O(usb_addr), .CONFIGURED_O(configured), .SUSPENDED_O(suspended), .TT_FLUSH_O(tt_flush),
		.REQ_ABORT_O(req_abort), .CONFIG_O(config_byte));
	hub_far_side_model u_far (.clk_i(clk), .ee_lat_i(ee_lat), .ee_hang_i(ee_hang), .ee_fit_i(ee_fit),
		.ee_byte_i(ee_byte), .smb_go_i(smb_go), .ee_start_i(ee_start), .ee_done_o(ee_done),
		.ee_present_o(ee_present), .ee_data_o(ee_data), .smb_done_o(smb_done));
	////////////////////////////////////////////////////////////////
	task automatic results();
		if (err_total == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [7:0] exp_cfg(input logic fit, input logic hang, input logic [7:0] b);
		return (fit && !hang) ? b : 8'h00;
	endfunction
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic hw_reset(input logic [1:0] sel, input int hold);
		int k;
		k = 0;
		@(posedge clk);
		rst_n <= 1'b0;
		cfg_sel <= sel;
		repeat (hold) @(posedge clk);
		chk("port_power", {28'h0, charge_en}, {28'h0, port_pwr});
		chk("port_enable", 32'h0, {28'h0, port_en});
		chk("phy_enable", 32'h0, {31'h0, phy_en});
		chk("osc_pll", 32'h0, {30'h0, osc_en, pll_en});
		chk("config_byte", 32'h0, {24'h0, config_byte});
		chk("req_abort", 32'h0, {31'h0, req_abort});
		rst_n <= 1'b1;
		do begin
			@(posedge clk);
			k++;
			#1;
		end while (phy_en !== 1'b1 && k < 100);
		chk("recovery", 32'(RCV) + 32'h1, 32'(k));
		chk("osc_pll_on", 32'h3, {30'h0, osc_en, pll_en});
	endtask
	task automatic wait_attach();
		n = 0;
		do begin
			@(posedge clk);
			n++;
			#1;
		end while (attach !== 1'b1 && n < 300);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end
	initial begin
		void'($urandom(32'h6e8c));
		charge_en <= 4'($urandom());
		hw_reset(2'h0, 12);
		wait_attach();
		chk("strap_attach", 32'h2, 32'(n));
		chk("strap_config", {24'h0, hub_seq_pkg::CONFIG_DEFAULT}, {24'h0, config_byte});
		chk("strap_ovr", 32'h1, {31'h0, strap_ovr});
		chk("out_drive", 32'h1, {31'h0, out_drv});
		cfg_sel <= 2'h2;
		apb(1'b0, hub_seq_pkg::STATUS_OFS, 32'h0);
		chk("mode", {30'h0, hub_seq_pkg::MODE_STRAP}, {30'h0, rd[5:4]});
		for (int k = 0; k < 3; k++) begin
			ee_byte = 8'($urandom());
			ee_fit = (k != 1);
			ee_hang = (k == 2);
			ee_lat = 4'(3 + $urandom_range(7));
			hw_reset(k == 1 ? 2'h3 : 2'h1, 40);
			wait_attach();
			chk("ee_bound", 32'h1, 32'(n <= 32'(EET) + 4));
			chk("ee_config", {24'h0, exp_cfg(ee_fit, ee_hang, ee_byte)}, {24'h0, config_byte});
			chk("ee_ovr", 32'h0, {31'h0, strap_ovr});
		end
		for (int k = 0; k < 2; k++) begin
			smb_go <= 1'b0;
			hw_reset(2'h2, 40);
			repeat (60) @(posedge clk);
			chk("smb_wait", 32'h0, {31'h0, attach});
			cfg_r = 8'($urandom());
			apb(1'b1, hub_seq_pkg::CONFIG_OFS, {24'h0, cfg_r});
			if (k == 0) begin
				apb(1'b1, hub_seq_pkg::CTRL_OFS, 32'h1);
			end else begin
				smb_go <= 1'b1;
			end
			wait_attach();
			chk("smb_attach", 32'h1, 32'(n <= 4));
			apb(1'b1, hub_seq_pkg::CONFIG_OFS, {24'h0, ~cfg_r});
			apb(1'b0, hub_seq_pkg::CONFIG_OFS, 32'h0);
			chk("protect", {24'h0, cfg_r}, rd);
			apb(1'b0, 8'h10, 32'h0);
			chk("unmapped", 32'h1, {31'h0, er});
		end
		ua = 7'($urandom_range(127, 1));
		charge_en <= 4'($urandom());
		apb(1'b1, hub_seq_pkg::DEV_OFS, 32'h100 | {25'h0, ua});
		#1;
		chk("usb_addr", {25'h0, ua}, {25'h0, usb_addr});
		chk("port_on", 32'hf, {28'h0, port_en});
		chk("configured", 32'h1, {31'h0, configured});
		@(posedge clk);
		suspend <= 1'b1;
		@(posedge clk);
		suspend <= 1'b0;
		repeat (20) @(posedge clk);
		chk("suspended", 32'h1, {31'h0, suspended});
		bus_rst <= 1'b1;
		@(posedge clk);
		bus_rst <= 1'b0;
		#1;
		chk("reset_addr", 32'h0, {25'h0, usb_addr});
		chk("reset_conf", 32'h0, {31'h0, configured});
		chk("reset_power", {28'h0, charge_en}, {28'h0, port_pwr});
		chk("tt_flush", 32'h1, {31'h0, tt_flush});
		chk("reset_wake", 32'h0, {31'h0, suspended});
		chk("reset_ports", 32'h0, {28'h0, port_en});
		@(posedge clk);
		req_start <= 1'b1;
		@(posedge clk);
		req_start <= 1'b0;
		wait_attach();
		n = 0;
		do begin
			@(posedge clk);
			n++;
			#1;
		end while (req_abort !== 1'b1 && n < 100);
		chk("req_timeout", 32'h1, 32'(n <= 32'(RQT) + 1));
		@(posedge clk);
		req_start <= 1'b1;
		@(posedge clk);
		req_start <= 1'b0;
		repeat (4) @(posedge clk);
		req_done <= 1'b1;
		@(posedge clk);
		req_done <= 1'b0;
		seen = 1'b0;
		repeat (40) @(posedge clk) if (req_abort === 1'b1) seen = 1'b1;
		chk("req_served", 32'h0, {31'h0, seen});
		results();
	end
endmodule // test_hub_reset_config_sequencer
